// file: logic/general_config_regs.svh
// register offsets, field positions and reset values of the general configuration bank
`ifndef GENERAL_CONFIG_REGS_SVH
`define GENERAL_CONFIG_REGS_SVH
`define ADDR_GENERAL_CONFIGURATION  8'h03
`define ADDR_RESERVED_GAP           8'h04
`define ADDR_REMOTE_TARGET          8'h06
`define ADDR_DES_ALIAS              8'h07
`define ADDR_TARGET_ALIAS           8'h09
`define ADDR_PLL_SOURCE_SELECT      8'h35
`define BIT_FORWARD_ALL             3
`define BIT_ALIAS_FORWARD           2
`define BIT_PLL_SOURCE_OVERRIDE     1
`define BIT_PIXEL_EDGE_SELECT       0
`define GENERAL_CONFIG_RESET        4'h5
`define LOW_FIELD_MASK              8'h0f
`define ZERO_BYTE                   8'h00
`endif

// file: logic/general_config_pkg.sv
// types shared by the general configuration bank
package general_config_pkg;
    typedef enum logic [1:0] {route_drop, route_alias, route_forward_all} route_t;
    typedef enum logic {pll_ext_oscillator, pll_direct_pixel} pll_source_t;
endpackage

// file: logic/forward_decider.sv
// decides whether a local transaction is forwarded and which address it carries
`timescale 1ns/100ps
`default_nettype none
`include "general_config_regs.svh"
module forward_decider
    import general_config_pkg::*;
(
    input  wire logic [6:0] target_id,
    input  wire logic [6:0] own_id,
    input  wire logic [6:0] remote_des_id,
    input  wire logic [6:0] remote_target_id,
    input  wire logic [6:0] des_alias,
    input  wire logic [6:0] target_alias,
    input  wire logic [6:0] remote_target_address,
    input  wire logic       forward_all,
    input  wire logic       alias_forward,
    output route_t          route,
    output logic [6:0]      forward_address
);
    // forward-all beats alias matching; own ID never forwarded
    always_comb
    begin
        route           = route_drop;
        forward_address = target_id;
        if (target_id == own_id)
            route = route_drop;
        else if (forward_all)
        begin
            route           = route_forward_all;         // [R01]
            forward_address = remote_target_address;     // [R02]
        end
        else if (alias_forward && (target_id == des_alias))
        begin
            route           = route_alias;               // [R03] [R04]
            forward_address = remote_des_id;
        end
        else if (alias_forward && (target_id == target_alias))
        begin
            route           = route_alias;               // [R03] [R04]
            forward_address = remote_target_id;
        end
    end
endmodule
`default_nettype wire

// file: logic/general_config.sv
// general configuration register, low half, with forwarding and clocking steering
// Notes on behaviour
// (R01) forward-all sends every non-own ID across
// (R02) forward-all traffic remapped to remote target address
// (R03) clear forward-all forwards only matching IDs
// (R04) alias forwarding enable resets set, gates aliases
// (R05) override set: PLL source from register field
// (R06) override clear: PLL source from strap pin
// (R07) edge select: 1 rising, 0 falling sampling
// (R08) reserved gap reads zero, writes ignored
`timescale 1ns/100ps
`default_nettype none
`include "general_config_regs.svh"
module general_config
    import general_config_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        reg_write,
    input  wire logic [7:0]  reg_address,
    input  wire logic [7:0]  reg_write_data,
    output logic [7:0]       reg_read_data,
    input  wire logic [6:0]  own_id,
    input  wire logic [6:0]  remote_des_id,
    input  wire logic [6:0]  remote_target_id,
    input  wire logic [6:0]  des_alias,
    input  wire logic [6:0]  target_alias,
    input  wire logic [6:0]  remote_target_address,
    input  wire logic        pll_source_field,
    input  wire logic        mode_strap,
    input  wire logic        txn_valid,
    input  wire logic [6:0]  txn_target_id,
    output logic             forward_valid,
    output logic [6:0]       forward_address,
    output logic             forward_all_active,
    output pll_source_t      pll_source,
    input  wire logic        pixel_clock_level,
    input  wire logic [11:0] pixel_data,
    output logic [11:0]      captured_data,
    output logic             captured_valid
);
    // stored fields; bits 7:4 of the register have no storage here
    logic [3:0]  general_configuration;
    logic        forward_all_on;
    logic        alias_forward_on;
    logic        pll_override_on;
    logic        rising_edge_select;
    logic        pixel_clock_prev;
    logic        edge_seen;
    route_t      route;
    logic [6:0]  next_forward_address;
    logic        next_forward_valid;
    pll_source_t next_pll_source;

    // true when a bus address selects the configuration register
    function automatic logic is_config_address(input logic [7:0] address);
        return address == `ADDR_GENERAL_CONFIGURATION;
    endfunction

    // true when the sampled pixel clock moved the selected way
    function automatic logic edge_matches(input logic level,
                                          input logic prev_level,
                                          input logic rising);
        if (rising)
            return level && !prev_level;
        else
            return !level && prev_level;
    endfunction

    // pll source choice: override field, otherwise strap pin
    function automatic pll_source_t select_pll_source(input logic override_on,
                                                      input logic field_value,
                                                      input logic strap_value);
        if (override_on)
            return pll_source_t'(field_value);       // [R05]
        else
            return pll_source_t'(strap_value);       // [R06]
    endfunction

    // register write; upper write bits are dropped on purpose
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            general_configuration <= `GENERAL_CONFIG_RESET;   // [R03] [R04] [R06] [R07]
        end
        else if (reg_write && is_config_address(reg_address))
        begin
            general_configuration <= reg_write_data[`BIT_FORWARD_ALL:`BIT_PIXEL_EDGE_SELECT];
        end
    end

    // named views of the stored fields
    assign forward_all_on     = general_configuration[`BIT_FORWARD_ALL];
    assign alias_forward_on   = general_configuration[`BIT_ALIAS_FORWARD];
    assign pll_override_on    = general_configuration[`BIT_PLL_SOURCE_OVERRIDE];
    assign rising_edge_select = general_configuration[`BIT_PIXEL_EDGE_SELECT];

    // register read; gap and unmapped locations read zero
    always_comb
    begin
        if (is_config_address(reg_address))
            reg_read_data = 8'(general_configuration);
        else
            reg_read_data = `ZERO_BYTE;                       // [R08]
    end

    forward_decider u_forward_decider
    (
        .target_id             (txn_target_id),
        .own_id                (own_id),
        .remote_des_id         (remote_des_id),
        .remote_target_id      (remote_target_id),
        .des_alias             (des_alias),
        .target_alias          (target_alias),
        .remote_target_address (remote_target_address),
        .forward_all           (forward_all_on),
        .alias_forward         (alias_forward_on),
        .route                 (route),
        .forward_address       (next_forward_address)
    );

    // a request leaves only when the decider picked a route
    assign next_forward_valid = txn_valid && (route != route_drop);   // [R01] [R03]

    // forward strobe, one cycle after the request edge
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            forward_valid <= 1'b0;
        end
        else
        begin
            forward_valid <= next_forward_valid;
        end
    end

    // forwarded address; tracks the decider, meaningful with the strobe
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            forward_address <= 7'h00;
        end
        else
        begin
            forward_address <= next_forward_address;   // [R02]
        end
    end

    // status copy of the forward-all field
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            forward_all_active <= 1'b0;
        end
        else
        begin
            forward_all_active <= forward_all_on;       // [R01]
        end
    end

    // registered choice so the source output never glitches
    assign next_pll_source = select_pll_source(pll_override_on, pll_source_field, mode_strap);

    // pll source register
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pll_source <= pll_ext_oscillator;
        end
        else
        begin
            pll_source <= next_pll_source;              // [R05] [R06]
        end
    end

    // edge detect against the previous pixel clock sample
    always_comb
    begin
        edge_seen = edge_matches(pixel_clock_level, pixel_clock_prev, rising_edge_select);   // [R07]
    end

    // previous sample; resets to the low idle level, so no false falling edge
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pixel_clock_prev <= 1'b0;
        end
        else
        begin
            pixel_clock_prev <= pixel_clock_level;
        end
    end

    // capture strobe, one cycle wide
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            captured_valid <= 1'b0;
        end
        else
        begin
            captured_valid <= edge_seen;                // [R07]
        end
    end

    // captured word; held until the next selected edge
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            captured_data <= 12'h000;
        end
        else if (edge_seen)
        begin
            captured_data <= pixel_data;                // [R07]
        end
    end
endmodule
`default_nettype wire

// file: verif/general_config_asserts.sv
// port checks of the general configuration bank
`timescale 1ns/100ps
`default_nettype none
module general_config_asserts
    import general_config_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        reg_write,
    input wire logic        txn_valid,
    input wire logic        forward_valid,
    input wire logic        forward_all_active,
    input wire logic        pll_source_field,
    input wire logic        mode_strap,
    input wire logic        pixel_clock_level,
    input wire logic        captured_valid,
    input wire logic [7:0]  reg_address,
    input wire logic [7:0]  reg_read_data,
    input wire logic [6:0]  own_id,
    input wire logic [6:0]  des_alias,
    input wire logic [6:0]  target_alias,
    input wire logic [6:0]  remote_des_id,
    input wire logic [6:0]  remote_target_address,
    input wire logic [6:0]  txn_target_id,
    input wire logic [6:0]  forward_address,
    input wire logic [11:0] pixel_data,
    input wire logic [11:0] captured_data,
    input wire pll_source_t pll_source
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // config seen through a read held on its address
    wire       cfg_ok = reg_address == 8'h03 && !reg_write;
    wire [3:0] cfg = reg_read_data[3:0];
    sequence s_txn; txn_valid && cfg_ok && txn_target_id != own_id; endsequence
    sequence s_cap; captured_valid && captured_data == $past(pixel_data); endsequence
    a_gap_reads_zero: assert property (
        reg_address != 8'h03 |-> reg_read_data == 8'h00) else $error("gap read");
    a_own_id_drop: assert property (
        txn_valid && txn_target_id == own_id |=> !forward_valid) else $error("own id sent");
    a_all_remap: assert property (
        s_txn ##0 cfg[3] |=> forward_valid && forward_address == $past(remote_target_address)) else $error("remap");
    a_all_status: assert property (
        cfg_ok |=> forward_all_active == $past(cfg[3])) else $error("status copy");
    a_nomatch_drop: assert property (
        s_txn ##0 !cfg[3] && txn_target_id != des_alias && txn_target_id != target_alias |=> !forward_valid)
        else $error("non-match sent");
    a_des_alias: assert property (
        s_txn ##0 cfg[3:2] == 2'b01 && txn_target_id == des_alias
        |=> forward_valid && forward_address == $past(remote_des_id)) else $error("alias map");
    a_alias_off: assert property (
        s_txn ##0 cfg[3:2] == 2'b00 |=> !forward_valid) else $error("alias off sent");
    a_pll_field: assert property (
        cfg_ok && cfg[1] |=> pll_source == $past(pll_source_field)) else $error("pll field");
    a_pll_strap: assert property (
        cfg_ok && !cfg[1] && $past(cfg_ok && !cfg[1] && reset_n) && $stable(mode_strap) |=> $stable(pll_source))
        else $error("pll strap");
    a_rise_capture: assert property (
        cfg_ok && cfg[0] && $rose(pixel_clock_level) |=> s_cap) else $error("rise capture");
    a_fall_capture: assert property (
        cfg_ok && !cfg[0] && $fell(pixel_clock_level) |=> s_cap) else $error("fall capture");
endmodule
bind general_config general_config_asserts i_chk (.*);
`default_nettype wire

// file: verif/host_model.sv
// local host model issuing transactions
`timescale 1ns/100ps
`default_nettype none
module host_model
(
    input  wire logic  clock,
    output logic       txn_valid,
    output logic [6:0] txn_target_id
);
    initial {txn_valid, txn_target_id} = '0;
    // one transaction, released with the id inverted
    task automatic send(input logic [6:0] id);
        @(negedge clock) {txn_valid, txn_target_id} = {1'b1, id};
        @(negedge clock) {txn_valid, txn_target_id} = {1'b0, ~id};
    endtask
endmodule
`default_nettype wire

// file: verif/general_config_tb.sv
// self-checking bench of the general configuration bank
`timescale 1ns/100ps
`default_nettype none
module general_config_tb
    import general_config_pkg::*;
;
    logic        clock, reset_n, reg_write, pll_source_field, mode_strap, pixel_clock_level, txn_valid;
    logic        forward_valid, forward_all_active, captured_valid;
    logic [7:0]  reg_address, reg_write_data, reg_read_data;
    logic [6:0]  own_id, remote_des_id, remote_target_id, des_alias, target_alias, remote_target_address;
    logic [6:0]  txn_target_id, forward_address, exp_q[$];
    logic [11:0] pixel_data, captured_data, cap_q[$];
    pll_source_t pll_source;
    int          err_total, checks;
    general_config i_dut (.*);
    host_model i_host (.*);
    initial forever #50 clock = ~clock;
    // comparisons
    task automatic cmp_reg(input logic [7:0] got, exp);
        checks++;
        err_total += (got !== exp);
        if (got !== exp) $display("[ERR] %0t value %h exp %h", $time, got, exp);
    endtask
    task automatic cmp_fwd(input logic [6:0] got, exp);
        checks++;
        err_total += (got !== exp);
        if (got !== exp) $display("[ERR] %0t forward %h exp %h", $time, got, exp);
    endtask
    task automatic cmp_bit(input logic got, exp);
        checks++;
        err_total += (got !== exp);
        if (got !== exp) $display("[ERR] %0t status %b exp %b", $time, got, exp);
    endtask
    task automatic cmp_cap(input logic [11:0] got, exp);
        checks++;
        err_total += (got !== exp);
        if (got !== exp) $display("[ERR] %0t capture %h exp %h", $time, got, exp);
    endtask
    // register access, address rests on the config
    task automatic wr(input logic [7:0] a, d);
        @(negedge clock) {reg_write, reg_address, reg_write_data} = {1'b1, a, d};
        @(negedge clock) {reg_write, reg_address} = {1'b0, 8'h03};
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(negedge clock) reg_address = a;
        @(negedge clock) cmp_reg(reg_read_data, e);
        reg_address = 8'h03;
    endtask
    // transaction with its expected forward noted
    task automatic txn(input logic [6:0] id, input bit fwd, input logic [6:0] e);
        if (fwd) exp_q.push_back(e);
        i_host.send(id);
    endtask
    // forwarded and captured results against the oldest note, mid-cycle
    always @(negedge clock)
    begin
        if (reset_n && forward_valid === 1'b1)
            cmp_fwd(forward_address, exp_q.size() ? exp_q.pop_front() : ~forward_address);
        if (reset_n && captured_valid === 1'b1)
            cmp_cap(captured_data, cap_q.size() ? cap_q.pop_front() : ~captured_data);
    end
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #1000000;
        err_total++;
        tally_and_finish;
    end
    initial
    begin
        {clock, reset_n, reg_write, pll_source_field, mode_strap, pixel_clock_level} = '0;
        {reg_address, reg_write_data, pixel_data, err_total, checks} = {8'h03, 8'h00, 12'h000, 64'h0};
        void'($urandom(70));
        {own_id, des_alias, target_alias} = {3'h1, 4'($urandom), 3'h2, 4'($urandom), 3'h3, 4'($urandom)};
        {remote_des_id, remote_target_id, remote_target_address} = 21'($urandom);
        repeat (12) @(negedge clock);
        reset_n = 1'b1;
        rd(8'h03, 8'h05);
        cmp_bit(forward_all_active, 1'b0);
        wr(8'h05, 8'hff);
        rd(8'h03, 8'h05);
        rd(8'h04, 8'h00);
        txn(des_alias, 1, remote_des_id);
        txn(target_alias, 1, remote_target_id);
        txn(own_id, 0, 0);
        txn(7'h50 | 7'($urandom % 16), 0, 0);
        wr(8'h03, 8'h01);
        txn(des_alias, 0, 0);
        wr(8'h03, 8'h08);
        @(negedge clock) cmp_bit(forward_all_active, 1'b1);
        repeat (4) txn(7'h50 | 7'($urandom % 16), 1, remote_target_address);
        txn(own_id, 0, 0);
        wr(8'h03, 8'h02);
        repeat (4)
        begin
            @(negedge clock) pll_source_field = 1'($urandom);
            @(negedge clock) cmp_bit(pll_source, pll_source_field);
        end
        for (int k = 1; k >= 0; k--)
        begin
            wr(8'h03, 8'(k));
            repeat (8)
            begin
                @(negedge clock) {pixel_clock_level, pixel_data} = {~pixel_clock_level, 12'($urandom)};
                if (pixel_clock_level == 1'(k)) cap_q.push_back(pixel_data);
            end
            repeat (6)
            begin
                @(negedge clock) {mode_strap, pll_source_field} = 2'($urandom);
                @(negedge clock) cmp_bit(pll_source, mode_strap);
            end
        end
        repeat (3) @(negedge clock);
        cmp_reg(8'(exp_q.size()), 8'h00);
        cmp_reg(8'(cap_q.size()), 8'h00);
        tally_and_finish;
    end
endmodule
`default_nettype wire
